/* verilog/sfg_pkg.sv */
/*
 * Shared constants for the serial flash write guard: array sizes, protection
 * granules, command opcodes, frame lengths, status field layout and states.
 * Assumes nothing of its surroundings; every design file refers to it by name.
 */
`default_nettype none

package sfg_pkg;

   // ----------------------------------------------------------------------
   // Array geometry
   // ----------------------------------------------------------------------
   localparam int unsigned MEM_BYTES_512K = 32'h0008_0000;
   localparam int unsigned MEM_BYTES_256K = 32'h0004_0000;
   localparam logic [23:0] BLOCK_BYTES = 24'h01_0000;
   localparam logic [23:0] SECTOR_BYTES = 24'h00_1000;
   localparam logic [23:0] HALF_BLOCK_BYTES = 24'h00_8000;
   localparam logic [23:0] SECTOR_MASK = 24'hff_f000;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   // ----------------------------------------------------------------------
   // Command opcodes
   // ----------------------------------------------------------------------
   localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
   localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h60;
   localparam logic [7:0] CMD_POWER_DOWN = 8'hb9;
   localparam logic [7:0] CMD_POWER_RELEASE = 8'hab;

   // ----------------------------------------------------------------------
   // Frame lengths and byte positions in whole bytes
   // ----------------------------------------------------------------------
   localparam logic [2:0] LEN_OPCODE = 3'h1;
   localparam logic [2:0] LEN_STATUS_ONE = 3'h2;
   localparam logic [2:0] LEN_STATUS_TWO = 3'h3;
   localparam logic [2:0] LEN_ADDRESSED = 3'h4;
   localparam logic [2:0] LEN_PROGRAM_MIN = 3'h5;
   localparam logic [2:0] LEN_SATURATE = 3'h7;
   localparam logic [2:0] IDX_OPCODE = 3'h0;
   localparam logic [2:0] IDX_ADDR_FIRST = 3'h1;
   localparam logic [2:0] IDX_ADDR_LAST = 3'h3;
   localparam logic [2:0] IDX_DATA = 3'h4;

   // ----------------------------------------------------------------------
   // Status layout
   // ----------------------------------------------------------------------
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam int unsigned SR_BUSY = 0;
   localparam int unsigned SR_WEL = 1;
   localparam int unsigned SR_BP_LSB = 2;
   localparam int unsigned SR_GUARD0 = 7;
   localparam int unsigned SR_GUARD1 = 8;
   localparam int unsigned SR_CMP = 14;
   localparam int unsigned HI_GUARD1 = 0;
   localparam int unsigned HI_CMP = 6;

   // ----------------------------------------------------------------------
   // Host timing, kept for the far side
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned POWER_TO_SELECT_DELAY_US = 70;
   localparam int unsigned POWER_TO_SELECT_CYCLES =
      (POWER_TO_SELECT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_INIT = 3'b000,
      ST_IDLE = 3'b001,
      ST_ERASE = 3'b010,
      ST_PRG_RD = 3'b011,
      ST_PRG_WR = 3'b100
   } sfg_state_t;

endpackage

`default_nettype wire

/* verilog/sfg_mem.sv */
/*
 * Byte array of the flash: one write port with a registered read beside it,
 * and a second registered read port for the user side.
 * Assumes a single clock; the contents have no reset and are filled by the
 * guard logic after reset.
 */
`timescale 1ns/10ps
`default_nettype none

module sfg_mem #(
   parameter int unsigned DEPTH = sfg_pkg::MEM_BYTES_512K,
   parameter int unsigned AW = $clog2(DEPTH)
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [AW-1:0] a_addr,
   input wire logic a_we,
   input wire logic [7:0] a_wdata,
   output logic [7:0] a_rdata,
   input wire logic [AW-1:0] b_addr,
   output logic [7:0] b_rdata
);

   logic [7:0] cells [DEPTH];

   always_ff @(posedge clk_sys) begin
      if (a_we) begin
         cells[a_addr] <= a_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         a_rdata <= '0;
         b_rdata <= '0;
      end else begin
         a_rdata <= cells[a_addr];
         b_rdata <= cells[b_addr];
      end
   end

endmodule

`default_nettype wire

/* verilog/sfg_write_guard.sv */
/*
 * Write guard of a serial NOR flash: frame capture on the serial clock,
 * command acceptance, write-enable latch, status bits, protected-range
 * decode, deep power-down lockout and the array fill, erase and program walk.
 * Assumes the host drives spi_cs_n, spi_clk and spi_mosi; spi_clk stops
 * between frames; wp_n and spi_cs_n are asynchronous pins.
 */
// Operation
// [RULE1] Erased and freshly delivered array bytes all read as all ones.
// [RULE2] Every status bit but busy is zero after reset; the busy bit reads one until the array fill after reset ends.
// [RULE3] Power-up reset puts the command machine into standby before commands.
// [RULE4] Array changes only after a complete valid frame has ended.
// [RULE5] A frame not ending on a byte boundary is discarded.
// [RULE6] Data-changing commands need the write-enable latch set beforehand.
// [RULE7] Protect bits select a readable region that refuses program and erase.
// [RULE8] Write-protect pin low freezes protect bits and both guard bits.
// [RULE9] In deep power-down only the release command is obeyed.
// [RULE10] Host keeps chip select high while supply ramps.
// [RULE11] Host waits the power-to-select delay before the first frame.
// [RULE12] 512KB, block mode, top: 64KB, 128KB, 256KB; zero protects nothing.
// [RULE13] 512KB, block mode, bottom select gives the same sizes at the bottom.
// [RULE14] 512KB: size bit2 in block mode, or sector pattern 111, protects all.
// [RULE15] 512KB sector mode top: 4KB, 8KB, 16KB, then 32KB for 10x, 110.
// [RULE16] 512KB sector mode bottom select moves those regions to the bottom.
// [RULE17] Complement bit in block mode protects the complement region.
// [RULE18] Complement bit in sector mode protects all but the chosen region.
// [RULE19] 256KB block mode ignores size bit2; 11 protects all.
// [RULE20] 256KB sector mode follows the same 4KB to 32KB patterns.
// [RULE21] Program or erase touching a protected byte is aborted unchanged.
// [RULE22] Protected range is decoded combinationally from current bits.
`timescale 1ns/10ps
`default_nettype none

module sfg_write_guard #(
   parameter int unsigned MEM_BYTES = sfg_pkg::MEM_BYTES_512K
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic spi_clk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   input wire logic wp_n,
   input wire logic [23:0] rd_addr,
   output logic [7:0] rd_data,
   output logic [15:0] status,
   output logic busy,
   output logic power_down,
   output logic cmd_reject
);

   localparam int unsigned AW = $clog2(MEM_BYTES);
   localparam logic [23:0] MEM = 24'(MEM_BYTES);
   localparam logic [23:0] MEM_LAST = 24'(MEM_BYTES - 1);

   // ----------------------------------------------------------------------
   // Link side, clocked by the serial clock
   // ----------------------------------------------------------------------
   // The first-bit marker is preset by the deselect itself, since the link
   // clock gives no edge after a frame ends.
   logic first_bit;
   logic [2:0] bit_cnt;
   logic [2:0] next_bit_cnt;
   logic [6:0] shift;
   logic [7:0] byte_hold;
   logic byte_tgl;
   logic partial;

   always_ff @(posedge spi_clk or posedge spi_cs_n or negedge resetn) begin
      if (!resetn) begin
         first_bit <= 1'b1;
      end else if (spi_cs_n) begin
         first_bit <= 1'b1;
      end else begin
         first_bit <= 1'b0;
      end
   end

   assign next_bit_cnt = first_bit ? 3'h1 : bit_cnt + 3'h1;

   always_ff @(posedge spi_clk or negedge resetn) begin
      if (!resetn) begin
         bit_cnt <= '0;
         shift <= '0;
         partial <= 1'b0;
      end else begin
         bit_cnt <= next_bit_cnt;
         shift <= {shift[5:0], spi_mosi};
         partial <= (next_bit_cnt != 3'h0); // [RULE5]
      end
   end

   always_ff @(posedge spi_clk or negedge resetn) begin
      if (!resetn) begin
         byte_hold <= '0;
         byte_tgl <= 1'b0;
      end else if (next_bit_cnt == 3'h0) begin
         byte_hold <= {shift, spi_mosi};
         byte_tgl <= ~byte_tgl;
      end
   end

   // ----------------------------------------------------------------------
   // Crossing into the system clock
   // ----------------------------------------------------------------------
   // Deselect is taken one stage later than the byte toggle so that the
   // last byte of a frame is always counted before the frame is judged.
   logic wp_s1, wp_s2, cs_s1, cs_s2, cs_s3, cs_s4;
   logic tg_s1, tg_s2, tg_s3, pt_s1, pt_s2;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {tg_s1, tg_s2, tg_s3, pt_s1, pt_s2} <= '0;
         // Pins start at their idle level, so release shows no false edge.
         {wp_s1, wp_s2, cs_s1, cs_s2, cs_s3, cs_s4} <= 6'h3f;
      end else begin
         {wp_s1, wp_s2} <= {wp_n, wp_s1};
         {cs_s1, cs_s2, cs_s3, cs_s4} <= {spi_cs_n, cs_s1, cs_s2, cs_s3};
         {tg_s1, tg_s2, tg_s3} <= {byte_tgl, tg_s1, tg_s2};
         {pt_s1, pt_s2} <= {partial, pt_s1};
      end
   end

   logic byte_ev, frame_start, frame_end;
   assign byte_ev = tg_s2 ^ tg_s3;
   assign frame_start = !cs_s3 && cs_s4;
   assign frame_end = cs_s3 && !cs_s4;

   // ----------------------------------------------------------------------
   // Frame collection
   // ----------------------------------------------------------------------
   logic [2:0] nb;
   logic [7:0] opc, dat;
   logic [23:0] addr;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         nb <= '0;
         opc <= '0;
         addr <= '0;
         dat <= '0;
      end else if (frame_start) begin
         nb <= '0;
      end else if (byte_ev) begin
         if (nb != sfg_pkg::LEN_SATURATE) begin
            nb <= nb + 3'h1;
         end
         if (nb == sfg_pkg::IDX_OPCODE) begin
            opc <= byte_hold;
         end else if (nb >= sfg_pkg::IDX_ADDR_FIRST && nb <= sfg_pkg::IDX_ADDR_LAST) begin
            addr <= {addr[15:0], byte_hold};
         end else if (nb == sfg_pkg::IDX_DATA) begin
            dat <= byte_hold;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Protected range decode
   // ----------------------------------------------------------------------
   logic [4:0] bp;
   logic cmp, write_enable_latch, guard0, guard1;

   function automatic logic [23:0] prot_size(input logic [4:0] b);
      logic [23:0] s;
      s = '0;
      if (!b[4]) begin
         if (b[2] && MEM_BYTES == sfg_pkg::MEM_BYTES_512K) begin
            s = MEM; // [RULE14]
         end else if (b[1:0] != 2'b00) begin
            s = sfg_pkg::BLOCK_BYTES << (b[1:0] - 2'b01); // [RULE12] [RULE13] [RULE19]
         end
      end else begin
         unique case (b[2:0])
            3'b000: s = '0;
            3'b111: s = MEM; // [RULE14] [RULE20]
            3'b100, 3'b101, 3'b110: s = sfg_pkg::HALF_BLOCK_BYTES; // [RULE15]
            default: s = sfg_pkg::SECTOR_BYTES << (b[1:0] - 2'b01); // [RULE15] [RULE20]
         endcase
      end
      return s;
   endfunction

   function automatic logic prot_at(input logic [23:0] a);
      logic [23:0] s;
      logic [23:0] m;
      logic hit;
      s = prot_size(bp);
      m = a & MEM_LAST;
      hit = bp[3] ? (m < s) : (m >= MEM - s); // [RULE16]
      return hit ^ cmp; // [RULE17] [RULE18]
   endfunction

   logic [23:0] cur_size;
   logic any_prot, addr_prot;
   assign cur_size = prot_size(bp); // [RULE22]
   assign any_prot = cmp ? (cur_size != MEM) : (cur_size != '0);
   assign addr_prot = prot_at(addr); // [RULE7]

   // ----------------------------------------------------------------------
   // Command acceptance
   // ----------------------------------------------------------------------
   sfg_pkg::sfg_state_t state;
   logic valid, exe, is_write_enable_cmd, is_wrdi, is_dp, is_rdp, go_wrsr, go_pp, go_se, go_ce, acc;

   assign valid = frame_end && !pt_s2 && nb != '0 && state == sfg_pkg::ST_IDLE; // [RULE4] [RULE5]
   assign exe = valid && !power_down; // [RULE9]
   assign is_write_enable_cmd = exe && opc == sfg_pkg::CMD_WRITE_ENABLE && nb == sfg_pkg::LEN_OPCODE;
   assign is_wrdi = exe && opc == sfg_pkg::CMD_WRITE_DISABLE && nb == sfg_pkg::LEN_OPCODE;
   assign is_dp = exe && opc == sfg_pkg::CMD_POWER_DOWN && nb == sfg_pkg::LEN_OPCODE;
   assign is_rdp = valid && power_down && opc == sfg_pkg::CMD_POWER_RELEASE;
   assign go_wrsr = exe && write_enable_latch && opc == sfg_pkg::CMD_WRITE_STATUS &&
                    (nb == sfg_pkg::LEN_STATUS_ONE || nb == sfg_pkg::LEN_STATUS_TWO); // [RULE6]
   assign go_pp = exe && write_enable_latch && opc == sfg_pkg::CMD_PAGE_PROGRAM &&
                  nb >= sfg_pkg::LEN_PROGRAM_MIN && !addr_prot; // [RULE6] [RULE21]
   assign go_se = exe && write_enable_latch && opc == sfg_pkg::CMD_SECTOR_ERASE &&
                  nb == sfg_pkg::LEN_ADDRESSED && !addr_prot; // [RULE21]
   assign go_ce = exe && write_enable_latch && opc == sfg_pkg::CMD_CHIP_ERASE &&
                  nb == sfg_pkg::LEN_OPCODE && !any_prot; // [RULE21]
   assign acc = is_write_enable_cmd || is_wrdi || is_dp || is_rdp || go_wrsr || go_pp || go_se || go_ce;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cmd_reject <= 1'b0;
      end else begin
         cmd_reject <= frame_end && (nb != '0 || pt_s2) && !acc; // [RULE5]
      end
   end

   // ----------------------------------------------------------------------
   // Status bits
   // ----------------------------------------------------------------------
   // A whole-byte write-status frame taken in standby outside deep power-down spends the latch; a
   // refused data-changing frame taken so also clears it; a misaligned frame leaves it as it was.
   logic [7:0] sr_lo, sr_hi;
   logic spends_wel;
   assign sr_lo = (nb == sfg_pkg::LEN_STATUS_ONE) ? addr[7:0] : addr[15:8];
   assign sr_hi = addr[7:0];
   assign spends_wel = exe && (opc == sfg_pkg::CMD_WRITE_STATUS || opc == sfg_pkg::CMD_PAGE_PROGRAM ||
                       opc == sfg_pkg::CMD_SECTOR_ERASE || opc == sfg_pkg::CMD_CHIP_ERASE);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         write_enable_latch <= 1'b0; // [RULE2]
      end else if (is_write_enable_cmd) begin
         write_enable_latch <= 1'b1; // [RULE6]
      end else if (is_wrdi || spends_wel) begin
         write_enable_latch <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bp <= '0; // [RULE2]
         guard0 <= 1'b0;
         guard1 <= 1'b0;
         cmp <= 1'b0;
      end else if (go_wrsr) begin
         cmp <= (nb == sfg_pkg::LEN_STATUS_TWO) ? sr_hi[sfg_pkg::HI_CMP] : cmp;
         if (wp_s2) begin
            bp <= sr_lo[sfg_pkg::SR_BP_LSB +: 5]; // [RULE8]
            guard0 <= sr_lo[sfg_pkg::SR_GUARD0];
            if (nb == sfg_pkg::LEN_STATUS_TWO) begin
               guard1 <= sr_hi[sfg_pkg::HI_GUARD1];
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         power_down <= 1'b0;
      end else if (is_dp) begin
         power_down <= 1'b1;
      end else if (is_rdp) begin
         power_down <= 1'b0; // [RULE9]
      end
   end

   // ----------------------------------------------------------------------
   // Array walk: fill after reset, erase, program
   // ----------------------------------------------------------------------
   // The fill after reset costs one clock per byte but lets the array be a
   // plain memory with no reset of its own.
   logic [23:0] wcnt, wend;
   logic [7:0] a_rdata;
   logic mem_we;
   logic [7:0] mem_wdata;
   logic [23:0] mem_addr;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= sfg_pkg::ST_INIT;
         wcnt <= '0;
         wend <= '0;
      end else begin
         unique case (state)
            sfg_pkg::ST_INIT: begin
               wcnt <= wcnt + 24'h00_0001;
               if (wcnt == MEM_LAST) begin
                  state <= sfg_pkg::ST_IDLE; // [RULE3]
               end
            end
            sfg_pkg::ST_IDLE: begin
               if (go_pp) begin
                  state <= sfg_pkg::ST_PRG_RD; // [RULE4]
               end else if (go_se) begin
                  state <= sfg_pkg::ST_ERASE;
                  wcnt <= addr & MEM_LAST & sfg_pkg::SECTOR_MASK;
                  wend <= (addr & MEM_LAST & sfg_pkg::SECTOR_MASK) + sfg_pkg::SECTOR_BYTES - 24'h00_0001;
               end else if (go_ce) begin
                  state <= sfg_pkg::ST_ERASE;
                  wcnt <= '0;
                  wend <= MEM_LAST;
               end
            end
            sfg_pkg::ST_ERASE: begin
               wcnt <= wcnt + 24'h00_0001;
               if (wcnt == wend) begin
                  state <= sfg_pkg::ST_IDLE;
               end
            end
            sfg_pkg::ST_PRG_RD: state <= sfg_pkg::ST_PRG_WR;
            sfg_pkg::ST_PRG_WR: state <= sfg_pkg::ST_IDLE;
            default: state <= sfg_pkg::ST_IDLE;
         endcase
      end
   end

   assign busy = state != sfg_pkg::ST_IDLE;
   assign mem_we = state == sfg_pkg::ST_INIT || state == sfg_pkg::ST_ERASE || state == sfg_pkg::ST_PRG_WR;
   assign mem_addr = (state == sfg_pkg::ST_INIT || state == sfg_pkg::ST_ERASE) ? wcnt : addr;
   // Programming can only clear bits, as in a real NOR cell.
   assign mem_wdata = (state == sfg_pkg::ST_PRG_WR) ? (dat & a_rdata) : sfg_pkg::ERASED_BYTE; // [RULE1]

   sfg_mem #(
      .DEPTH(MEM_BYTES),
      .AW(AW)
   ) u_mem (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .a_addr(mem_addr[AW-1:0]),
      .a_we(mem_we),
      .a_wdata(mem_wdata),
      .a_rdata(a_rdata),
      .b_addr(rd_addr[AW-1:0]),
      .b_rdata(rd_data)
   );

   always_comb begin
      status = sfg_pkg::STATUS_RESET;
      status[sfg_pkg::SR_BUSY] = busy;
      status[sfg_pkg::SR_WEL] = write_enable_latch;
      status[sfg_pkg::SR_BP_LSB +: 5] = bp;
      status[sfg_pkg::SR_GUARD0] = guard0;
      status[sfg_pkg::SR_GUARD1] = guard1;
      status[sfg_pkg::SR_CMP] = cmp;
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_fill_erased: assert property ( // [RULE1]
      (state == sfg_pkg::ST_INIT || state == sfg_pkg::ST_ERASE) |-> mem_we && mem_wdata == 8'hff)
      else $error("erase or fill wrote a value other than all ones");

   a_status_cleared: assert property ( // [RULE2]
      $rose(resetn) |-> status[15:1] == 15'h0000 && busy && state == sfg_pkg::ST_INIT)
      else $error("status not clear after reset");

   a_write_after_end: assert property ( // [RULE4]
      $rose(state == sfg_pkg::ST_PRG_RD) |-> $past(frame_end) ##1 state == sfg_pkg::ST_PRG_WR ##1 !busy)
      else $error("program did not follow a frame end in two steps");

   a_partial_drop: assert property ( // [RULE5]
      frame_end && pt_s2 |=> $stable(write_enable_latch) && $stable(bp) && !$rose(busy) && cmd_reject)
      else $error("misaligned frame was not discarded");

   a_latch_needed: assert property ( // [RULE6]
      (state == sfg_pkg::ST_IDLE) ##1 (state == sfg_pkg::ST_ERASE || state == sfg_pkg::ST_PRG_RD)
      |-> $past(write_enable_latch) && !write_enable_latch)
      else $error("array change started without the write-enable latch");

   a_wp_freeze: assert property ( // [RULE8]
      !wp_s2 |=> $stable(bp) && $stable(guard0) && $stable(guard1))
      else $error("protect or guard bits changed while write protect held");

   a_sleep_lock: assert property ( // [RULE9]
      power_down && frame_end && opc != sfg_pkg::CMD_POWER_RELEASE |=> power_down && !busy && $stable(status))
      else $error("command obeyed during deep power-down");

   a_prot_abort: assert property ( // [RULE21]
      state == sfg_pkg::ST_PRG_WR |-> !prot_at(addr))
      else $error("program reached a protected byte");

   a_top_64k: assert property ( // [RULE12]
      bp == 5'b00001 && !cmp |-> prot_at(MEM - 24'h01_0000) && !prot_at(MEM - 24'h01_0001))
      else $error("top block region decoded wrongly");

   a_bottom_4k: assert property ( // [RULE16]
      bp == 5'b11001 && !cmp |-> prot_at(24'h00_0fff) && !prot_at(24'h00_1000))
      else $error("bottom sector region decoded wrongly");

endmodule

`default_nettype wire

/* bench/sfg_host_model.sv */
/*
 * Host serial controller model: frames MSB first on a 160 ns serial clock.
 * Assumes the bench calls frame() only while the guard is idle.
 */
`timescale 1ns/10ps
`default_nettype none
module sfg_host_model (
   output var logic spi_clk,
   output var logic spi_cs_n,
   output var logic spi_mosi
);
   initial begin
      spi_clk = 1'h0;
      spi_cs_n = 1'h1;
      spi_mosi = 1'h0;
   end
   // The clock stands still outside frames; the data line never keeps a stale bit.
   task automatic frame(input logic [39:0] d, input int n);
      spi_cs_n = 1'h0;
      for (int i = 0; i < n; i++) begin
         spi_mosi = d[39-i];
         #80 spi_clk = 1'h1;
         #80 spi_clk = 1'h0;
      end
      #40 spi_cs_n = 1'h1;
      spi_mosi = ~spi_mosi;
      #200;
   endtask
endmodule
`default_nettype wire

/* bench/serial_flash_write_guard_tb_top.sv */
/*
 * Self-checking bench of the write guard, 256KB variant, random with corners.
 * Assumes the host model drives the serial pins; the array fill is not shortened.
 */
`timescale 1ns/10ps
`default_nettype none
module serial_flash_write_guard_tb_top;
   localparam int MB = sfg_pkg::MEM_BYTES_256K;
   logic clk_sys, resetn, wp_n, spi_clk, spi_cs_n, spi_mosi, busy, power_down, cmd_reject, r;
   logic [23:0] rd_addr, a;
   logic [7:0] rd_data, d;
   logic [15:0] status;
   logic [4:0] bp;
   logic c;
   int bad_count = 0, n_tests = 0, rej = 0, cyc = 0, seed = 87;
   logic [7:0] shadow [int];
   logic [4:0] bps [8] = '{5'h00, 5'h01, 5'h0b, 5'h03, 5'h11, 5'h19, 5'h17, 5'h14};
   logic [23:0] edges [8] = '{24'h03_0000, 24'h02_ffff, 24'h00_ffff, 24'h01_0000,
      24'h03_f000, 24'h00_0fff, 24'h03_8000, 24'h00_8000};
   sfg_host_model host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
   sfg_write_guard #(.MEM_BYTES(MB)) dut (.clk_sys(clk_sys), .resetn(resetn), .spi_clk(spi_clk),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .wp_n(wp_n), .rd_addr(rd_addr), .rd_data(rd_data),
      .status(status), .busy(busy), .power_down(power_down), .cmd_reject(cmd_reject));
   initial begin
      clk_sys = 1'h0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) begin
      cyc <= cyc + 1;
      if (cmd_reject === 1'h1) rej <= rej + 1;
      if (cyc == 600000) begin
         bad_count++;
         close_out();
      end
   end
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Sends one frame, lets the judgement land, then waits up to 9000 cycles for a walk to end.
   task automatic send(input logic [39:0] f, input int n, output logic rj);
      int r0;
      r0 = rej;
      host.frame(f, n);
      repeat (12) @(negedge clk_sys);
      for (int k = 0; k < 9000 && busy !== 1'h0; k++) @(negedge clk_sys);
      rj = (rej != r0);
   endtask
   task automatic rd(input logic [23:0] x, output logic [7:0] v);
      @(negedge clk_sys) rd_addr = x;
      @(negedge clk_sys) v = rd_data;
   endtask
   task automatic prog(input logic [23:0] x, input logic [7:0] v, input logic w, input logic ok);
      logic rj;
      logic [7:0] got;
      if (w) send({8'h06, 32'h0000_0000}, 8, rj);
      send({8'h02, x, v}, 40, rj);
      cmp(rj, !ok, "program refusal");
      if (ok) shadow[x] = (shadow.exists(x) ? shadow[x] : 8'hff) & v;
      rd(x, got);
      cmp(got, shadow.exists(x) ? shadow[x] : 8'hff, "array byte");
   endtask
   task automatic wrsr(input logic [4:0] b, input logic cb);
      logic rj;
      send({8'h06, 32'h0000_0000}, 8, rj);
      send({8'h01, 1'h0, b, 2'h0, 1'h0, cb, 6'h00, 16'h0000}, 24, rj);
   endtask
   function automatic logic prot(input logic [4:0] b, input logic cb, input logic [23:0] x);
      int sz;
      if (!b[4]) sz = (b[1:0] == 2'h3) ? MB : b[1:0] * 32'h0001_0000;
      else if (b[2:0] == 3'h7) sz = MB;
      else sz = b[2] ? 32'h0000_8000 : (b[1:0] == 2'h0 ? 0 : 32'h0000_0800 << b[1:0]);
      return cb ^ (b[3] ? (x < sz) : (x >= MB - sz));
   endfunction
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      resetn = 1'h0;
      wp_n = 1'h1;
      rd_addr = 24'h00_0000;
      repeat (10) @(negedge clk_sys);
      cmp(busy, 1, "busy in reset");
      resetn = 1'h1;
      for (int k = 0; k < 300000 && busy !== 1'h0; k++) @(negedge clk_sys);
      cmp(status, 16'h0000, "status after reset");
      for (int k = 0; k < 4; k++) begin
         rd(24'($unsigned($random(seed)) % MB), d);
         cmp(d, 8'hff, "erased byte");
      end
      $display("reset test done");
      prog(24'h00_1234, 8'h5a, 1'h0, 1'h0);
      prog(24'h00_1234, 8'h5a, 1'h1, 1'h1);
      send({8'h06, 32'h0000_0000}, 9, r);
      cmp({r, status[1]}, 2'h2, "odd length frame");
      send({8'h06, 32'h0000_0000}, 8, r);
      send({8'h02, 24'h00_2000, 8'h00}, 39, r);
      cmp(r, 1'h1, "short program frame");
      prog(24'h00_2000, 8'hff, 1'h1, 1'h1);
      send({8'h06, 32'h0000_0000}, 8, r);
      send({8'h04, 32'h0000_0000}, 8, r);
      cmp({r, status[1]}, 2'h0, "write disable");
      send({8'h06, 32'h0000_0000}, 8, r);
      send({8'h20, 24'h00_1fff, 8'h00}, 32, r);
      rd(24'h00_1234, d);
      cmp({r, d}, 9'h0ff, "sector erase");
      shadow.delete(24'h00_1234);
      $display("latch and length test done");
      for (int k = 0; k < 16; k++) begin
         bp = (k < 8) ? bps[k] : 5'($random(seed));
         c = (k < 8) ? 1'h0 : 1'($random(seed));
         wrsr(bp, c);
         cmp({status[14], status[6:2]}, {c, bp}, "protect bits");
         a = k[0] ? edges[k / 2] : 24'($unsigned($random(seed)) % MB);
         d = 8'($random(seed));
         prog(a, d, 1'h1, !prot(bp, c, a));
      end
      $display("protection test done");
      @(negedge clk_sys) wp_n = 1'h0;
      wrsr(~bp, ~c);
      cmp({status[14], status[6:2]}, {~c, bp}, "frozen protect bits");
      @(negedge clk_sys) wp_n = 1'h1;
      send({8'hb9, 32'h0000_0000}, 8, r);
      cmp(power_down, 1, "power down");
      send({8'h06, 32'h0000_0000}, 8, r);
      cmp({r, status[1]}, 2'h2, "command in power down");
      send({8'hab, 32'h0000_0000}, 8, r);
      cmp(power_down, 0, "release");
      $display("lockout test done");
      close_out();
   end
endmodule
`default_nettype wire
